//--- logic/spwd_supervisor.sv
// Supervisor top: kick watchdogs, reset one-shot, window, sources, levels
`timescale 1ns/1ps
module spwd_supervisor #(
  parameter int unsigned WD_CYC    = spwd_pkg::WD_PERIOD_CYC,
  parameter int unsigned GAP_CYC   = spwd_pkg::KICK_GAP_CYC,
  parameter int unsigned RST_CYC   = spwd_pkg::RST_PULSE_CYC,
  parameter int unsigned DEB_CYC   = spwd_pkg::DEBOUNCE_CYC
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          kick,
  input  wire logic [spwd_pkg::TAP_W-1:0]    tap_count_setting,
  input  wire logic                          reset_active_low,
  input  wire spwd_pkg::spwd_cmp_type        cmp,
  input  wire logic [spwd_pkg::NUM_SRC-1:0]  supply_detect,
  input  wire logic [spwd_pkg::NUM_LVL-1:0]  level_comparator,
  input  wire logic                          sensor_request,
  output logic                               sys_reset,
  output logic                               window_irq,
  output spwd_pkg::spwd_src_type             source,
  output logic [spwd_pkg::NUM_WIN-1:0]       level_window,
  output logic                               sensor_power_enable,
  output logic                               sensor_alarm,
  output logic                               wd_timeout
);
  localparam int unsigned WW = $clog2(WD_CYC + 1);
  localparam int unsigned GW = $clog2(GAP_CYC + 1);
  localparam int unsigned RW = $clog2(RST_CYC + 1);
  localparam int unsigned TW = spwd_pkg::TAP_W;

  // ==========================================================
  // Kick edge detect
  logic kick_q;
  logic kick_rise;
  always_ff @(posedge sys_clk) begin
    if (rst) kick_q <= 1'b0;
    else     kick_q <= kick;
  end
  assign kick_rise = kick & ~kick_q;

  // ==========================================================
  // Period one-shot counter
  logic [WW-1:0] period_cnt;
  logic          period_one_shot_counter;
  logic          period_end;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      period_cnt              <= '0;
      period_one_shot_counter <= 1'b0;
    end else if (!period_one_shot_counter) begin
      period_one_shot_counter <= 1'b1;
      period_cnt              <= '0;
    end else if (period_cnt == WW'(WD_CYC - 1)) begin
      period_one_shot_counter <= 1'b0;
    end else begin
      period_cnt <= period_cnt + 1'b1;
    end
  end
  // Falling edge of one-shot, i.e. rising of its inverse, ends the period
  assign period_end = period_one_shot_counter && (period_cnt == WW'(WD_CYC - 1));

  // ==========================================================
  // Pulse counting pipe delay
  logic [TW:0] pulse_cnt;
  logic        tap_reached;
  logic        inverted_tap_output;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pulse_cnt <= '0;
    end else if (!period_one_shot_counter) begin
      pulse_cnt <= '0;
    end else if (kick_rise && !tap_reached) begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end
  assign tap_reached         = pulse_cnt >= ({1'b0, tap_count_setting} + 1'b1);
  assign inverted_tap_output = ~tap_reached;

  // ==========================================================
  // Pulse-check flop
  logic pulse_check_flop;
  always_ff @(posedge sys_clk) begin
    if (rst)             pulse_check_flop <= 1'b0;
    else if (period_end) pulse_check_flop <= inverted_tap_output;
    else                 pulse_check_flop <= 1'b0;
  end

  // ==========================================================
  // Frequency detect: two counter/delay cells
  logic [GW-1:0] gap_cnt;
  logic          freq_low;
  logic          freq_hold;
  logic          gap_expired;
  // Expiry in the same cycle as a kick still counts as a slow gap
  assign gap_expired = (gap_cnt == GW'(GAP_CYC - 1)) && !freq_low;
  always_ff @(posedge sys_clk) begin
    if (rst || kick_rise) begin
      gap_cnt  <= '0;
      freq_low <= 1'b0;
    end else if (gap_cnt == GW'(GAP_CYC - 1)) begin
      freq_low <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end
  // Second cell: one-cycle timeout event per slow gap
  always_ff @(posedge sys_clk) begin
    if (rst) freq_hold <= 1'b0;
    else     freq_hold <= gap_expired;
  end
  assign wd_timeout = freq_hold | pulse_check_flop;

  // ==========================================================
  // Reset request and one-shot
  logic                          reset_request;
  logic [RW-1:0]                 rst_cnt;
  spwd_pkg::spwd_rst_state_type  rst_state;
  assign reset_request = cmp.undervoltage | wd_timeout;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_state <= spwd_pkg::SPWD_IDLE;
      rst_cnt   <= '0;
    end else begin
      case (rst_state)
        spwd_pkg::SPWD_IDLE: begin
          rst_cnt <= '0;
          if (reset_request) rst_state <= spwd_pkg::SPWD_PULSE;
        end
        spwd_pkg::SPWD_PULSE: begin
          if (rst_cnt == RW'(RST_CYC - 1)) rst_state <= spwd_pkg::SPWD_HOLD;
          else                             rst_cnt <= rst_cnt + 1'b1;
        end
        spwd_pkg::SPWD_HOLD: begin
          // Wait for undervoltage to clear before re-arming
          if (!cmp.undervoltage) rst_state <= spwd_pkg::SPWD_IDLE;
        end
        default: rst_state <= spwd_pkg::SPWD_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) sys_reset <= 1'b0;
    else     sys_reset <= (rst_state == spwd_pkg::SPWD_PULSE) ^ reset_active_low;
  end

  // ==========================================================
  // Window interrupt
  always_ff @(posedge sys_clk) begin
    if (rst) window_irq <= 1'b0;
    else     window_irq <= ~cmp.low_side | cmp.high_side;
  end

  // ==========================================================
  // Supply detect debounce and priority
  logic [spwd_pkg::NUM_SRC-1:0] supply_ok;
  logic [spwd_pkg::NUM_LVL-1:0] level_ok;
  genvar gi;
  generate
    for (gi = 0; gi < spwd_pkg::NUM_SRC; gi++) begin : g_src
      spwd_debounce #(.COUNT(DEB_CYC)) u_deb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .raw     (supply_detect[gi]),
        .filt    (supply_ok[gi])
      );
    end
  endgenerate

  // Input 0 has highest priority
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      source <= '{select: '0, none: 1'b1};
    end else if (supply_ok[0]) begin
      source <= '{select: 3'h1, none: 1'b0};
    end else if (supply_ok[1]) begin
      source <= '{select: 3'h2, none: 1'b0};
    end else if (supply_ok[2]) begin
      source <= '{select: 3'h4, none: 1'b0};
    end else begin
      source <= '{select: 3'h0, none: 1'b1};
    end
  end

  // ==========================================================
  // Level windows: middle comparator debounced
  spwd_debounce #(.COUNT(DEB_CYC)) u_lvl_deb (
    .sys_clk (sys_clk),
    .rst     (rst),
    .raw     (level_comparator[1]),
    .filt    (level_ok[1])
  );
  assign level_ok[0] = level_comparator[0];
  assign level_ok[2] = level_comparator[2];

  logic [2:0] level_lookup;
  assign level_lookup = level_ok;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_window <= '0;
    end else begin
      case (level_lookup)
        3'h0:    level_window <= 4'h1;
        3'h1:    level_window <= 4'h2;
        3'h3:    level_window <= 4'h4;
        3'h7:    level_window <= 4'h8;
        default: level_window <= 4'h0;
      endcase
    end
  end

  // ==========================================================
  // Temperature sensor gating
  always_ff @(posedge sys_clk) begin
    if (rst) sensor_power_enable <= 1'b0;
    else     sensor_power_enable <= sensor_request;
  end
  // Comparator only counts while it is powered
  always_ff @(posedge sys_clk) begin
    if (rst) sensor_alarm <= 1'b0;
    else     sensor_alarm <= sensor_power_enable & cmp.sensor;
  end

endmodule // spwd_supervisor

//--- logic/spwd_pkg.sv
// Package: constants and carrier types for the supply pulse watchdog supervisor
// Summary of operation
// - Reset when fewer kicks than the pulse count arrive in one period.
// - A one-shot counter sets the watchdog period window for counting kicks.
// - Required pulse count equals the tap count setting plus one.
// - Period end, the one-shot falling, makes the pulse-check flop sample.
// - Inverted tap output feeds the pulse-check flop; sampled high means too few.
// - Host kicks periodically; missing kicks cause an automatic reset.
// - Two counter/delay cells detect kick frequency; too slow means timeout.
// - Undervoltage or watchdog timeout, either one, requests a reset.
// - Reset request fires a fixed-length reset pulse; polarity selectable.
// - Interrupt when low-side comparator low or high-side comparator high.
// - Each supply-presence detector is debounced by a delay counter.
// - Fixed priority selects among the three detected power inputs.
// - One sensor power enable powers the sensor and its comparator.
// - Debounce delay sits between the middle level comparator and the 3-bit lookup.
// - Lookup decodes comparator outputs into distinct level windows.
package spwd_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned WD_PERIOD_US   = 1000;
  localparam int unsigned WD_PERIOD_CYC  = WD_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned KICK_GAP_US    = 400;
  localparam int unsigned KICK_GAP_CYC   = KICK_GAP_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned RST_PULSE_US   = 100;
  localparam int unsigned RST_PULSE_CYC  = RST_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_US    = 1;
  localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_US * 1000 / CLK_PERIOD_NS;

  // ==========================================================
  // Pulse count and power sources
  localparam int unsigned TAP_W          = 4;
  localparam logic [3:0]  TAP_COUNT_RST  = 4'h2;
  localparam int unsigned NUM_SRC        = 3;
  localparam int unsigned NUM_LVL        = 3;
  localparam int unsigned NUM_WIN        = 4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic low_side;
    logic high_side;
    logic undervoltage;
    logic sensor;
  } spwd_cmp_type;

  typedef struct packed {
    logic [NUM_SRC-1:0] select;
    logic               none;
  } spwd_src_type;

  typedef enum logic [2:0] {
    SPWD_IDLE  = 3'h1,
    SPWD_PULSE = 3'h2,
    SPWD_HOLD  = 3'h4
  } spwd_rst_state_type;

endpackage

//--- logic/spwd_debounce.sv
// Counter/delay cell used as a debounce filter
`timescale 1ns/1ps
module spwd_debounce #(
  parameter int unsigned COUNT = 100
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      filt
);
  localparam int unsigned CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt;

  // Output follows input only after it stood stable for COUNT cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt  <= '0;
      filt <= 1'b0;
    end else if (raw == filt) begin
      cnt <= '0;
    end else if (cnt == CW'(COUNT - 1)) begin
      cnt  <= '0;
      filt <= raw;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // spwd_debounce

//--- bench/spwd_supervisor_properties.sv
// Checker: port-level properties of the supervisor
`timescale 1ns/1ps
module spwd_supervisor_properties #(
  parameter int unsigned WD_CYC  = 50,
  parameter int unsigned GAP_CYC = 20,
  parameter int unsigned RST_CYC = 5,
  parameter int unsigned DEB_CYC = 3
) (
  input wire logic                   sys_clk,
  input wire logic                   rst,
  input wire logic                   kick,
  input wire logic                   reset_active_low,
  input wire spwd_pkg::spwd_cmp_type cmp,
  input wire logic                   sensor_request,
  input wire logic                   sys_reset,
  input wire logic                   window_irq,
  input wire spwd_pkg::spwd_src_type source,
  input wire logic [3:0]             level_window,
  input wire logic                   sensor_power_enable,
  input wire logic                   sensor_alarm,
  input wire logic                   wd_timeout
);
  logic        act;
  logic        seen_to;
  logic [15:0] run_len;
  logic [15:0] idle_len;
  assign act = sys_reset ^ reset_active_low;
  always_ff @(posedge sys_clk) begin
    if (rst || !act) run_len <= 16'h0000;
    else run_len <= run_len + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || kick) idle_len <= 16'h0000;
    else if (idle_len != 16'hFFFF) idle_len <= idle_len + 16'h0001;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || kick) seen_to <= 1'b0;
    else if (wd_timeout) seen_to <= 1'b1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence uv_start;
    $rose(cmp.undervoltage) && !act && !$past(act);
  endsequence
  sequence pulse_on;
    ##2 act [*2];
  endsequence
  irq_window_a: assert property (
    1'b1 |=> window_irq == $past(!cmp.low_side | cmp.high_side))
    else $error("window interrupt mismatch");
  uv_reset_a: assert property (uv_start |-> pulse_on)
    else $error("undervoltage gave no reset");
  reset_cause_a: assert property (
    $rose(act) |-> $past(wd_timeout, 2) || $past(cmp.undervoltage, 2))
    else $error("reset without cause");
  pulse_len_a: assert property ($fell(act) && !$past(rst, 2) |-> run_len == RST_CYC)
    else $error("reset pulse length wrong");
  timeout_pulse_a: assert property (wd_timeout |=> !wd_timeout)
    else $error("timeout longer than one cycle");
  stall_detect_a: assert property (idle_len == GAP_CYC + 3 |-> seen_to)
    else $error("kick stall not detected");
  sensor_gate_a: assert property (
    1'b1 |=> sensor_power_enable == $past(sensor_request)
    && sensor_alarm == $past(sensor_power_enable & cmp.sensor))
    else $error("sensor enable or alarm wrong");
  level_onehot_a: assert property ($onehot0(level_window))
    else $error("level window not one-hot");
  source_sel_a: assert property (
    $onehot0(source.select) && source.none == (source.select == 3'h0))
    else $error("source select invalid");
endmodule // spwd_supervisor_properties
bind spwd_supervisor spwd_supervisor_properties #(.WD_CYC(WD_CYC), .GAP_CYC(GAP_CYC),
  .RST_CYC(RST_CYC), .DEB_CYC(DEB_CYC)) props_inst (.sys_clk(sys_clk), .rst(rst), .kick(kick),
  .reset_active_low(reset_active_low), .cmp(cmp), .sensor_request(sensor_request),
  .sys_reset(sys_reset), .window_irq(window_irq), .source(source), .level_window(level_window),
  .sensor_power_enable(sensor_power_enable), .sensor_alarm(sensor_alarm), .wd_timeout(wd_timeout));

//--- bench/spwd_host.sv
// Host model: periodic kick pulses
`timescale 1ns/1ps
module spwd_host (
  input  wire logic       sys_clk,
  input  wire logic       run,
  input  wire logic [7:0] gap,
  output logic            kick
);
  logic [7:0] cnt = 8'h00;
  initial kick = 1'b0;
  // One-cycle kick every gap cycles while running
  always @(negedge sys_clk) begin
    if (run && cnt >= gap - 8'h01) begin
      kick <= 1'b1;
      cnt <= 8'h00;
    end else begin
      kick <= 1'b0;
      cnt <= run ? cnt + 8'h01 : 8'h00;
    end
  end
endmodule // spwd_host

//--- bench/tb.sv
// Testbench for the supply pulse watchdog supervisor
`timescale 1ns/1ps
module tb;
  logic                   sys_clk, rst, run, ral, sreq;
  logic                   kick, sys_reset, window_irq, spe, alarm, wd_to;
  logic [3:0]             tap, lvl_win;
  logic [2:0]             sdet, lvl;
  logic [7:0]             gap;
  spwd_pkg::spwd_cmp_type cmp;
  spwd_pkg::spwd_src_type src;
  int                     failures = 0, n_tests = 0, cyc = 0;
  spwd_supervisor #(.WD_CYC(50), .GAP_CYC(20), .RST_CYC(5), .DEB_CYC(3)) spwd_supervisor_inst (
    .sys_clk(sys_clk), .rst(rst), .kick(kick), .tap_count_setting(tap),
    .reset_active_low(ral), .cmp(cmp), .supply_detect(sdet), .level_comparator(lvl),
    .sensor_request(sreq), .sys_reset(sys_reset), .window_irq(window_irq), .source(src),
    .level_window(lvl_win), .sensor_power_enable(spe), .sensor_alarm(alarm), .wd_timeout(wd_to));
  spwd_host spwd_host_inst (.sys_clk(sys_clk), .run(run), .gap(gap), .kick(kick));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset();
    rst = 1'b1;
    tick(8);
    rst = 1'b0;
    tick(1);
  endtask
  // Waits for a reset pulse and measures it
  task automatic t_pulse(input int lim);
    int n, m;
    n = 0;
    m = 0;
    while (sys_reset === ral && n < lim) begin
      tick(1);
      n++;
    end
    chk("reset_seen", 8'h01, {7'h00, n < lim});
    while (sys_reset !== ral && m < 20) begin
      tick(1);
      m++;
    end
    chk("reset_len", 8'h05, m[7:0]);
  endtask
  task automatic t_window();
    for (int i = 0; i < 4; i++) begin
      cmp.low_side = i[0];
      cmp.high_side = i[1];
      sreq = i[0];
      cmp.sensor = i[1];
      tick(2);
      chk("window_irq", {7'h00, !i[0] | i[1]}, {7'h00, window_irq});
      chk("sensor_en", {7'h00, i[0]}, {7'h00, spe});
      chk("sensor_alarm", {7'h00, i[0] & i[1]}, {7'h00, alarm});
    end
  endtask
  task automatic t_source();
    logic [2:0] e;
    for (int i = 0; i < 8; i++) begin
      sdet = i[2:0];
      tick(8);
      e = i[0] ? 3'h1 : i[1] ? 3'h2 : i[2] ? 3'h4 : 3'h0;
      chk("source", {4'h0, e, e == 3'h0}, {4'h0, src});
    end
    sdet = 3'h4;
    tick(8);
    sdet = 3'h1;
    tick(1);
    chk("source_glitch", 8'h08, {4'h0, src});
    sdet = 3'h4;
    tick(8);
    chk("source_glitch", 8'h08, {4'h0, src});
  endtask
  task automatic t_level();
    logic [2:0] pat [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
    logic [3:0] win [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
    for (int i = 0; i < 5; i++) begin
      lvl = pat[i];
      tick(8);
      chk("level_window", {4'h0, win[i]}, {4'h0, lvl_win});
    end
    lvl = 3'h1;
    tick(8);
    lvl = 3'h3;
    tick(1);
    chk("level_glitch", 8'h02, {4'h0, lvl_win});
    lvl = 3'h1;
    tick(8);
    chk("level_glitch", 8'h02, {4'h0, lvl_win});
  endtask
  task automatic t_kicks();
    int n;
    n = 0;
    tap = 4'h5;
    gap = 8'h08;
    run = 1'b1;
    do_reset();
    repeat (200) begin
      tick(1);
      if (wd_to !== 1'b0) n++;
    end
    chk("timeouts", 8'h00, n[7:0]);
    gap = 8'h0B;
    t_pulse(130);
    // Enough kicks per period, but gaps longer than the frequency limit
    tap = 4'h0;
    gap = 8'h1E;
    t_pulse(80);
  endtask
  task automatic t_uv(input logic pol);
    run = 1'b1;
    gap = 8'h08;
    tap = 4'h0;
    ral = pol;
    do_reset();
    chk("idle_level", {7'h00, pol}, {7'h00, sys_reset});
    tick(2);
    cmp.undervoltage = 1'b1;
    t_pulse(4);
    cmp.undervoltage = 1'b0;
    tick(4);
  endtask
  initial begin
    run = 1'b0;
    ral = 1'b0;
    sreq = 1'b0;
    tap = 4'h0;
    gap = 8'h08;
    cmp = '0;
    sdet = 3'h0;
    lvl = 3'h0;
    do_reset();
    t_window();
    t_source();
    t_level();
    t_kicks();
    t_uv(1'b0);
    t_uv(1'b1);
    summarize();
  end
endmodule // tb
